// file: rtl/drive_command_monitor_regs.sv
`timescale 1ns/10ps

// Functional notes
// (R1) Operation word: run, reverse, fault, reset, terminals
// (R2) Command words read/write; frequency in 0.01 Hz
// (R3) Torque command signed, limited to +/-16384
// (R4) Monitor words read-only; writes change nothing
// (R5) Status bits 0-2: run, reverse, zero hold
// (R6) Status bit 3 fault, bit 4 alarm
// (R7) Status bit 5 speed agree, bit 6 ready
// (R8) Status bit 7 alternate frequency, 8 remote run
// (R9) Status bit 9 torque mode, 10 hold selected
// (R10) Output frequency and command echo, 0.01 Hz
// (R11) Output current in 0.1 A steps
// (R12) Output and bus voltage in 0.1 V
// (R13) Terminal word: inputs, relays, third output
// (R14) First analog input 0 to full scale
// (R15) Second analog input 0 to full scale
// (R16) Analog outputs span -1000 to 1000
// (R17) Alarm codes 0-10: none, deviation, external faults
// (R18) Alarm codes 11-21 for remaining alarms
// (R19) Fault code zero unless fault present
// (R20) Failed access: function with top bit, exception
// (R21) Reserved words and bits read zero, ignore writes
module drive_command_monitor_regs
  import drive_regs_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,

  // Register access port from the serial link framer.
  input  wire logic                    req_valid,
  input  wire logic [7:0]              req_func,
  input  wire logic [15:0]             req_addr,
  input  wire logic [15:0]             req_wdata,
  output logic                         rsp_valid,
  output logic [7:0]                   rsp_func,
  output logic [15:0]                  rsp_data,
  output logic [7:0]                   rsp_exception,

  // Command outputs toward the drive core.
  output logic                         run_cmd,
  output logic                         reverse_cmd,
  output logic                         option_card_external_fault,
  output logic                         fault_reset_cmd,
  output logic [7:0]                   virtual_terminal,
  output logic [15:0]                  frequency_cmd,
  output logic signed [15:0]           torque_cmd,

  // Drive state inputs.
  input  wire logic                    motor_running,
  input  wire logic                    motor_reverse,
  input  wire logic                    zero_hold_active,
  input  wire logic                    fault_present,
  input  wire logic                    speed_agree,
  input  wire logic                    drive_ready,
  input  wire logic                    freq_from_alternate,
  input  wire logic                    run_from_remote,
  input  wire logic                    torque_mode,
  input  wire logic                    zero_hold_selected,

  // Alarm flags and the number of the active fault.
  input  wire logic [ALARM_COUNT-1:0]  alarm_flags,
  input  wire logic [15:0]             fault_code_in,

  // Measured values, already scaled by the drive core.
  input  wire logic [15:0]             output_frequency_in,
  input  wire logic [15:0]             output_current_in,
  input  wire logic [15:0]             output_voltage_in,
  input  wire logic [15:0]             dc_bus_voltage_in,

  // Terminal, relay and digital output states.
  input  wire logic [7:0]              input_terminals,
  input  wire logic                    relay_first_on,
  input  wire logic                    relay_second_on,
  input  wire logic                    digital_output_third,

  // Analog levels in display counts.
  input  wire logic [15:0]             analog_input_first,
  input  wire logic [15:0]             analog_input_second,
  input  wire logic signed [15:0]      analog_output_first,
  input  wire logic signed [15:0]      analog_output_second
);

  // Stored command words and the registered answer.
  logic [15:0]        operation_command_ff;
  logic [15:0]        frequency_command_ff;
  logic signed [15:0] torque_command_ff;
  logic               rsp_valid_ff;
  logic [7:0]         rsp_func_ff;
  logic [15:0]        rsp_data_ff;
  logic [7:0]         rsp_exception_ff;

  // Request decode.
  logic               is_read;
  logic               is_write;
  logic               addr_command;
  logic               addr_monitor;
  logic               write_ok;

  // Assembled monitor words.
  logic [15:0]        operating_status;
  logic [15:0]        terminal_status;
  logic [15:0]        alarm_code;
  logic [15:0]        fault_code;

  // Analog channels, first channel at index 0.
  logic [15:0]        ain_raw    [2];
  logic [15:0]        ain_level  [2];
  logic signed [15:0] aout_raw   [2];
  logic signed [15:0] aout_level [2];

  // Next values of the command and answer registers.
  logic signed [15:0] nxt_torque;
  logic [15:0]        nxt_rdata;
  logic [7:0]         nxt_exception;

  // Request decode: the command block spans four words, the monitor block fifteen.
  assign is_read      = (req_func == FUNC_READ);
  assign is_write     = (req_func == FUNC_WRITE);

  // Address windows; only the command block takes writes.
  assign addr_command = (req_addr >= ADDR_RESERVED_COMMAND)
                        && (req_addr <= ADDR_TORQUE_COMMAND);
  assign addr_monitor = (req_addr >= ADDR_RESERVED_MONITOR)
                        && (req_addr <= ADDR_ANALOG_OUT_SECOND);
  assign write_ok     = req_valid && is_write && addr_command;

  // Torque writes outside the rated span are held at the nearest limit.
  always_comb
  begin
    // The word is read as two's complement before the limits apply.
    nxt_torque = $signed(req_wdata);
    if (nxt_torque > TORQUE_LIMIT_POS)
    begin
      nxt_torque = TORQUE_LIMIT_POS; // R3
    end
    else if (nxt_torque < TORQUE_LIMIT_NEG)
    begin
      nxt_torque = TORQUE_LIMIT_NEG; // R3
    end
  end

  // Operation command word; unused bits are never stored.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      operation_command_ff <= OPERATION_COMMAND_RESET;
    end
    else if (write_ok && (req_addr == ADDR_OPERATION_COMMAND))
    begin
      operation_command_ff <= req_wdata & OPC_WRITE_MASK; // R1 R21
    end
  end

  // Frequency command word, unsigned in hundredths of a hertz.
  // Any 16-bit value is stored as written.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frequency_command_ff <= FREQUENCY_COMMAND_RESET;
    end
    else if (write_ok && (req_addr == ADDR_FREQUENCY_COMMAND))
    begin
      frequency_command_ff <= req_wdata; // R2
    end
  end

  // Torque command word, signed and limited.
  // A clamped value replaces the write; no refusal is sent.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      torque_command_ff <= TORQUE_COMMAND_RESET;
    end
    else if (write_ok && (req_addr == ADDR_TORQUE_COMMAND))
    begin
      torque_command_ff <= nxt_torque; // R3
    end
  end

  // Command fields toward the drive core.
  assign run_cmd                    = operation_command_ff[OPC_RUN_BIT]; // R1
  assign reverse_cmd                = operation_command_ff[OPC_REVERSE_BIT]; // R1
  assign option_card_external_fault = operation_command_ff[OPC_EXT_FAULT_BIT]; // R1
  assign fault_reset_cmd            = operation_command_ff[OPC_FAULT_RESET_BIT]; // R1
  assign virtual_terminal           = operation_command_ff[OPC_TERMINAL_LSB +: 8]; // R1

  // Whole command words as stored; torque holds the limited value.
  assign frequency_cmd              = frequency_command_ff;
  assign torque_cmd                 = torque_command_ff;

  // Operating status word; bits 11 to 15 stay zero.
  // Bit 4 summarises every alarm flag at once.
  assign operating_status = {5'h00,
                             zero_hold_selected,   // R9
                             torque_mode,          // R9
                             run_from_remote,      // R8
                             freq_from_alternate,  // R8
                             drive_ready,          // R7
                             speed_agree,          // R7
                             |alarm_flags,         // R6
                             fault_present,        // R6
                             zero_hold_active,     // R5
                             motor_reverse,        // R5
                             motor_running};       // R5

  // Terminal status word; bits 8 to 11 and 15 stay zero.
  always_comb
  begin
    terminal_status = 16'h0000;
    terminal_status[TST_INPUT_LSB +: 8] = input_terminals; // R13
    terminal_status[TST_RELAY1_BIT]     = relay_first_on; // R13
    terminal_status[TST_RELAY2_BIT]     = relay_second_on; // R13
    terminal_status[TST_DOUT3_BIT]      = digital_output_third; // R13
  end

  // Alarm code: the lowest-numbered active alarm wins.
  always_comb
  begin
    alarm_code = ALARM_NONE;
    // Scanning downward lets the lowest active flag assign last.
    for (int i = ALARM_COUNT - 1; i >= 0; i--)
    begin
      if (alarm_flags[i])
      begin
        alarm_code = 16'(i + 1); // R17 R18
      end
    end
  end

  // Fault code reads zero whenever no fault is flagged.
  // A stale number on the input never shows without a fault.
  assign fault_code = fault_present ? fault_code_in : FAULT_NONE; // R19

  // Channel views of the analog pins, so that one loop serves both.
  assign ain_raw[0]  = analog_input_first;
  assign ain_raw[1]  = analog_input_second;
  assign aout_raw[0] = analog_output_first;
  assign aout_raw[1] = analog_output_second;

  // Each channel saturates on its own, so a level past the span never wraps.
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_analog
    // Input levels stop at full scale.
    assign ain_level[ch]  = (ain_raw[ch] > ANALOG_IN_FULL) ? ANALOG_IN_FULL
                            : ain_raw[ch]; // R14 R15
    // Output levels stop at both ends of the span.
    assign aout_level[ch] = (aout_raw[ch] > ANALOG_OUT_POS) ? ANALOG_OUT_POS
                            : (aout_raw[ch] < ANALOG_OUT_NEG) ? ANALOG_OUT_NEG
                            : aout_raw[ch]; // R16
  end

  // Read multiplexer; reserved words read as zero.
  // Addresses outside both blocks are refused before this value is used.
  always_comb
  begin
    case (req_addr)
      ADDR_OPERATION_COMMAND: nxt_rdata = operation_command_ff; // R2
      ADDR_FREQUENCY_COMMAND: nxt_rdata = frequency_command_ff; // R2
      ADDR_TORQUE_COMMAND:    nxt_rdata = torque_command_ff; // R2
      ADDR_OPERATING_STATUS:  nxt_rdata = operating_status;
      ADDR_FREQ_CMD_ECHO:     nxt_rdata = frequency_command_ff; // R10
      ADDR_OUTPUT_FREQUENCY:  nxt_rdata = output_frequency_in; // R10
      ADDR_OUTPUT_CURRENT:    nxt_rdata = output_current_in; // R11
      ADDR_OUTPUT_VOLTAGE:    nxt_rdata = output_voltage_in; // R12
      ADDR_DC_BUS_VOLTAGE:    nxt_rdata = dc_bus_voltage_in; // R12
      ADDR_ALARM_CODE:        nxt_rdata = alarm_code;
      ADDR_FAULT_CODE:        nxt_rdata = fault_code;
      ADDR_TERMINAL_STATUS:   nxt_rdata = terminal_status;
      ADDR_ANALOG_IN_FIRST:   nxt_rdata = ain_level[0];
      ADDR_ANALOG_IN_SECOND:  nxt_rdata = ain_level[1];
      ADDR_ANALOG_OUT_FIRST:  nxt_rdata = aout_level[0];
      ADDR_ANALOG_OUT_SECOND: nxt_rdata = aout_level[1];
      default:                nxt_rdata = 16'h0000; // R21
    endcase
  end

  // Answer class of the request on the port; a bad function beats a bad address.
  always_comb
  begin
    nxt_exception = EXC_NONE;
    if (!is_read && !is_write)
    begin
      nxt_exception = EXC_ILLEGAL_FUNC; // R20
    end
    else if (is_read && !(addr_command || addr_monitor))
    begin
      nxt_exception = EXC_ILLEGAL_ADDR; // R20
    end
    else if (is_write && !addr_command)
    begin
      nxt_exception = EXC_ILLEGAL_ADDR; // R4 R20
    end
  end

  // Answer strobe, one cycle after each request taken.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rsp_valid_ff <= 1'b0;
    end
    else
    begin
      rsp_valid_ff <= req_valid;
    end
  end

  // Answer function: the request's code, top bit set on any refusal.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rsp_func_ff <= 8'h00;
    end
    else if (req_valid)
    begin
      rsp_func_ff <= (nxt_exception == EXC_NONE) ? req_func
                     : (req_func | FUNC_ERROR_FLAG); // R20
    end
  end

  // Exception code, held until the next answer.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rsp_exception_ff <= EXC_NONE;
    end
    else if (req_valid)
    begin
      rsp_exception_ff <= nxt_exception; // R20
    end
  end

  // Answer data: read word or write echo, zero on a refusal.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rsp_data_ff <= 16'h0000;
    end
    else if (req_valid)
    begin
      if (nxt_exception != EXC_NONE)
      begin
        rsp_data_ff <= 16'h0000;
      end
      else if (is_read)
      begin
        rsp_data_ff <= nxt_rdata; // R2
      end
      else
      begin
        rsp_data_ff <= req_wdata;
      end
    end
  end

  // Answer ports come straight from their flip-flops.
  assign rsp_valid     = rsp_valid_ff;
  assign rsp_func      = rsp_func_ff;
  assign rsp_data      = rsp_data_ff;
  assign rsp_exception = rsp_exception_ff;

endmodule

// file: rtl/drive_regs_pkg.sv
package drive_regs_pkg;

  // Word addresses of the command block.
  localparam logic [15:0] ADDR_RESERVED_COMMAND  = 16'h2400;
  localparam logic [15:0] ADDR_OPERATION_COMMAND = 16'h2401;
  localparam logic [15:0] ADDR_FREQUENCY_COMMAND = 16'h2402;
  localparam logic [15:0] ADDR_TORQUE_COMMAND    = 16'h2403;

  // Word addresses of the monitor block.
  localparam logic [15:0] ADDR_RESERVED_MONITOR  = 16'h2420;
  localparam logic [15:0] ADDR_OPERATING_STATUS  = 16'h2421;
  localparam logic [15:0] ADDR_FREQ_CMD_ECHO     = 16'h2422;
  localparam logic [15:0] ADDR_OUTPUT_FREQUENCY  = 16'h2423;
  localparam logic [15:0] ADDR_OUTPUT_CURRENT    = 16'h2424;
  localparam logic [15:0] ADDR_OUTPUT_VOLTAGE    = 16'h2425;
  localparam logic [15:0] ADDR_DC_BUS_VOLTAGE    = 16'h2426;
  localparam logic [15:0] ADDR_ALARM_CODE        = 16'h2427;
  localparam logic [15:0] ADDR_FAULT_CODE        = 16'h2428;
  localparam logic [15:0] ADDR_TERMINAL_STATUS   = 16'h2429;
  localparam logic [15:0] ADDR_ANALOG_IN_FIRST   = 16'h242a;
  localparam logic [15:0] ADDR_ANALOG_IN_SECOND  = 16'h242b;
  localparam logic [15:0] ADDR_RESERVED_ANALOG   = 16'h242c;
  localparam logic [15:0] ADDR_ANALOG_OUT_FIRST  = 16'h242d;
  localparam logic [15:0] ADDR_ANALOG_OUT_SECOND = 16'h242e;

  // Operation command field positions.
  localparam int OPC_RUN_BIT         = 0;
  localparam int OPC_REVERSE_BIT     = 1;
  localparam int OPC_EXT_FAULT_BIT   = 2;
  localparam int OPC_FAULT_RESET_BIT = 3;
  localparam int OPC_TERMINAL_LSB    = 8;
  localparam logic [15:0] OPC_WRITE_MASK = 16'hff0f;

  // Terminal status field positions.
  localparam int TST_INPUT_LSB  = 0;
  localparam int TST_RELAY1_BIT = 12;
  localparam int TST_RELAY2_BIT = 13;
  localparam int TST_DOUT3_BIT  = 14;

  // Reset values of the command words.
  localparam logic [15:0] OPERATION_COMMAND_RESET = 16'h0000;
  localparam logic [15:0] FREQUENCY_COMMAND_RESET = 16'h0000;
  localparam logic [15:0] TORQUE_COMMAND_RESET    = 16'h0000;

  // Value limits of the command and monitor words.
  localparam logic signed [15:0] TORQUE_LIMIT_POS = 16'sh4000;
  localparam logic signed [15:0] TORQUE_LIMIT_NEG = -16'sh4000;
  localparam logic [15:0]        ANALOG_IN_FULL   = 16'h03e8;
  localparam logic signed [15:0] ANALOG_OUT_POS   = 16'sh03e8;
  localparam logic signed [15:0] ANALOG_OUT_NEG   = -16'sh03e8;

  // Alarm sources, one flag per nonzero alarm code.
  localparam int ALARM_COUNT = 21;
  localparam logic [15:0] ALARM_NONE = 16'h0000;
  localparam logic [15:0] FAULT_NONE = 16'h0000;

  // Function codes and exception codes of the access port.
  localparam logic [7:0] FUNC_READ         = 8'h03;
  localparam logic [7:0] FUNC_WRITE        = 8'h06;
  localparam logic [7:0] FUNC_ERROR_FLAG   = 8'h80;
  localparam logic [7:0] EXC_NONE          = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_FUNC  = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR  = 8'h02;

endpackage

// file: tb/drive_regs_assertions.sv
`timescale 1ns/10ps
module drive_regs_assertions
  import drive_regs_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               reset_n,
  input wire logic               req_valid,
  input wire logic [7:0]         req_func,
  input wire logic [15:0]        req_addr,
  input wire logic [15:0]        req_wdata,
  input wire logic               rsp_valid,
  input wire logic [7:0]         rsp_func,
  input wire logic [15:0]        rsp_data,
  input wire logic [7:0]         rsp_exception,
  input wire logic               run_cmd,
  input wire logic [7:0]         virtual_terminal,
  input wire logic [15:0]        frequency_cmd,
  input wire logic signed [15:0] torque_cmd,
  input wire logic               motor_running,
  input wire logic               fault_present
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  logic rd_req;
  logic wr_req;
  // Decoded read and write requests.
  assign rd_req = req_valid && req_func == FUNC_READ;
  assign wr_req = req_valid && req_func == FUNC_WRITE;
  property p_answer;
    req_valid |=> rsp_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_no_spurious;
    !req_valid |=> !rsp_valid;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("answer without request");
  property p_bad_func;
    req_valid && !rd_req && !wr_req |=> rsp_func == ($past(req_func) | FUNC_ERROR_FLAG)
      && rsp_exception == EXC_ILLEGAL_FUNC && rsp_data == 16'h0000;
  endproperty
  a_bad_func: assert property (p_bad_func) else $error("bad function answer");
  property p_op_write;
    wr_req && req_addr == ADDR_OPERATION_COMMAND |=> run_cmd == $past(req_wdata[0])
      && virtual_terminal == $past(req_wdata[15:8]);
  endproperty
  a_op_write: assert property (p_op_write) else $error("operation word not applied");
  property p_freq_write;
    wr_req && req_addr == ADDR_FREQUENCY_COMMAND |=> frequency_cmd == $past(req_wdata);
  endproperty
  a_freq_write: assert property (p_freq_write) else $error("frequency not applied");
  property p_ro_write;
    wr_req && req_addr >= ADDR_RESERVED_MONITOR |=> rsp_exception == EXC_ILLEGAL_ADDR
      && $stable(frequency_cmd) && $stable(torque_cmd);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("monitor write accepted");
  property p_status;
    rd_req && req_addr == ADDR_OPERATING_STATUS |=> rsp_data[0] == $past(motor_running)
      && rsp_data[3] == $past(fault_present) && rsp_data[15:11] == 5'h00;
  endproperty
  a_status: assert property (p_status) else $error("status word wrong");
  property p_fault_zero;
    rd_req && req_addr == ADDR_FAULT_CODE && !fault_present |=> rsp_data == FAULT_NONE;
  endproperty
  a_fault_zero: assert property (p_fault_zero) else $error("fault code without fault");
  property p_reserved;
    rd_req && (req_addr == ADDR_RESERVED_MONITOR || req_addr == ADDR_RESERVED_ANALOG)
      |=> rsp_data == 16'h0000 && rsp_exception == EXC_NONE;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved word not zero");
  property p_torque_range;
    torque_cmd <= TORQUE_LIMIT_POS && torque_cmd >= TORQUE_LIMIT_NEG;
  endproperty
  a_torque_range: assert property (p_torque_range) else $error("torque out of range");
  // Main scenarios reached.
  c_write_op: cover property (wr_req && req_addr == ADDR_OPERATION_COMMAND);
  c_refused: cover property (rsp_valid && rsp_exception == EXC_ILLEGAL_ADDR);
  c_status: cover property (rd_req && req_addr == ADDR_OPERATING_STATUS);
endmodule

bind drive_command_monitor_regs drive_regs_assertions chk_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .req_valid(req_valid), .req_func(req_func),
  .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_func(rsp_func),
  .rsp_data(rsp_data), .rsp_exception(rsp_exception), .run_cmd(run_cmd),
  .virtual_terminal(virtual_terminal), .frequency_cmd(frequency_cmd),
  .torque_cmd(torque_cmd), .motor_running(motor_running), .fault_present(fault_present)
);

// file: tb/link_master_model.sv
`timescale 1ns/10ps
module link_master_model (
  input  wire logic        clk_sys,
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  rsp_func,
  input  wire logic [15:0] rsp_data,
  input  wire logic [7:0]  rsp_exception,
  output logic             req_valid,
  output logic [7:0]       req_func,
  output logic [15:0]      req_addr,
  output logic [15:0]      req_wdata
);
  bit timed_out;
  // Link idle at start.
  initial
  begin
    req_valid = 1'b0;
    {req_func, req_addr, req_wdata} = '0;
  end
  // One word request, held for its taking edge, then the answer is captured.
  task automatic access(input logic [7:0] f, input logic [15:0] a, d,
                        output logic [7:0] rf, output logic [15:0] q, output logic [7:0] e);
    @(posedge clk_sys);
    #1;
    req_valid = 1'b1;
    {req_func, req_addr, req_wdata} = {f, a, d};
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    {req_func, req_addr, req_wdata} = ~{f, a, d};
    timed_out = 1'b1;
    for (int i = 0; i < 4 && timed_out; i++)
    begin
      if (rsp_valid === 1'b1)
      begin
        {rf, q, e} = {rsp_func, rsp_data, rsp_exception};
        timed_out = 1'b0;
      end
      else
        @(posedge clk_sys);
    end
  endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import drive_regs_pkg::*;
;
  logic               clk_sys, reset_n, req_valid, rsp_valid, run_cmd, rev, efl, frst;
  logic [7:0]         req_func, rsp_func, rsp_exception, virtual_terminal, term, rf, re;
  logic [15:0]        req_addr, req_wdata, rsp_data, frequency_cmd, rq, fcode, ofr, ocur;
  logic [15:0]        ovol, dcv, ain1, ain2, aout1, aout2;
  logic signed [15:0] torque_cmd;
  logic [9:0]         sts;
  logic [20:0]        alm;
  logic [2:0]         rly;
  int                 fails, samples_checked;

  drive_command_monitor_regs dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .req_valid(req_valid), .req_func(req_func),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_func(rsp_func),
    .rsp_data(rsp_data), .rsp_exception(rsp_exception), .run_cmd(run_cmd),
    .reverse_cmd(rev), .option_card_external_fault(efl), .fault_reset_cmd(frst),
    .virtual_terminal(virtual_terminal), .frequency_cmd(frequency_cmd),
    .torque_cmd(torque_cmd), .motor_running(sts[0]), .motor_reverse(sts[1]),
    .zero_hold_active(sts[2]), .fault_present(sts[3]), .speed_agree(sts[4]),
    .drive_ready(sts[5]), .freq_from_alternate(sts[6]), .run_from_remote(sts[7]),
    .torque_mode(sts[8]), .zero_hold_selected(sts[9]), .alarm_flags(alm),
    .fault_code_in(fcode), .output_frequency_in(ofr), .output_current_in(ocur),
    .output_voltage_in(ovol), .dc_bus_voltage_in(dcv), .input_terminals(term),
    .relay_first_on(rly[0]), .relay_second_on(rly[1]), .digital_output_third(rly[2]),
    .analog_input_first(ain1), .analog_input_second(ain2), .analog_output_first(aout1),
    .analog_output_second(aout2)
  );
  link_master_model host (
    .clk_sys(clk_sys), .rsp_valid(rsp_valid), .rsp_func(rsp_func), .rsp_data(rsp_data),
    .rsp_exception(rsp_exception), .req_valid(req_valid), .req_func(req_func),
    .req_addr(req_addr), .req_wdata(req_wdata)
  );
  // Free running system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Comparison of one observed value with its expectation.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One access whose answer function, data and exception are all judged.
  task automatic acc(input logic [7:0] f, input logic [15:0] a, d, input logic [31:0] exp);
    host.access(f, a, d, rf, rq, re);
    if (host.timed_out)
    begin
      fails++;
      give_verdict();
    end
    else
    begin
      chk({rf, rq, re}, exp);
    end
  endtask
  task automatic rd(input logic [15:0] a, exp);
    acc(FUNC_READ, a, 16'h0000, {FUNC_READ, exp, EXC_NONE});
  endtask
  task automatic wr(input logic [15:0] a, d);
    acc(FUNC_WRITE, a, d, {FUNC_WRITE, d, EXC_NONE});
  endtask
  // Command words: reset value, fields, reserved bits, echo and torque limits.
  task automatic t_commands();
    rd(ADDR_OPERATION_COMMAND, OPERATION_COMMAND_RESET);
    rd(ADDR_FREQUENCY_COMMAND, FREQUENCY_COMMAND_RESET);
    rd(ADDR_TORQUE_COMMAND, TORQUE_COMMAND_RESET);
    wr(ADDR_OPERATION_COMMAND, 16'hffff);
    rd(ADDR_OPERATION_COMMAND, 16'hff0f);
    wr(ADDR_OPERATION_COMMAND, 16'ha50d);
    chk({20'h0, virtual_terminal, frst, efl, rev, run_cmd}, 32'h0000_0a5d);
    wr(ADDR_FREQUENCY_COMMAND, 16'h1770);
    chk({16'h0, frequency_cmd}, 32'h0000_1770);
    rd(ADDR_FREQ_CMD_ECHO, 16'h1770);
    wr(ADDR_TORQUE_COMMAND, 16'hc000);
    rd(ADDR_TORQUE_COMMAND, 16'hc000);
    wr(ADDR_TORQUE_COMMAND, 16'h7fff);
    chk({16'h0, torque_cmd}, 32'h0000_4000);
    wr(ADDR_TORQUE_COMMAND, 16'h8000);
    chk({16'h0, torque_cmd}, 32'h0000_c000);
  endtask
  // Each status source alone, then the alarm summary bit.
  task automatic t_status();
    for (int b = 0; b < 10; b++)
    begin
      sts = 10'h001 << b;
      rd(ADDR_OPERATING_STATUS, 16'h0001 << (b > 3 ? b + 1 : b));
    end
    sts = 10'h000;
    alm = 21'h000400;
    rd(ADDR_OPERATING_STATUS, 16'h0010);
  endtask
  // Every alarm code, the lowest of two, and no alarm.
  task automatic t_alarm();
    for (int b = 0; b < 21; b++)
    begin
      alm = 21'h000001 << b;
      rd(ADDR_ALARM_CODE, 16'(b + 1));
    end
    alm = 21'h100004;
    rd(ADDR_ALARM_CODE, 16'h0003);
    alm = 21'h000000;
    rd(ADDR_ALARM_CODE, ALARM_NONE);
  endtask
  // Measured words, fault code gating and a refused monitor write.
  task automatic t_monitor();
    {fcode, ofr, ocur, ovol, dcv} = {16'h0035, 16'h1234, 16'h00a1, 16'h0dc0, 16'h1356};
    rd(ADDR_OUTPUT_FREQUENCY, 16'h1234);
    rd(ADDR_OUTPUT_CURRENT, 16'h00a1);
    rd(ADDR_OUTPUT_VOLTAGE, 16'h0dc0);
    rd(ADDR_DC_BUS_VOLTAGE, 16'h1356);
    rd(ADDR_FAULT_CODE, FAULT_NONE);
    sts = 10'h008;
    rd(ADDR_FAULT_CODE, 16'h0035);
    acc(FUNC_WRITE, ADDR_OUTPUT_FREQUENCY, 16'hffff, {8'h86, 16'h0, EXC_ILLEGAL_ADDR});
    rd(ADDR_OUTPUT_FREQUENCY, 16'h1234);
  endtask
  // Terminal word and clamped analog levels.
  task automatic t_io();
    {term, rly} = {8'ha5, 3'b101};
    {ain1, ain2, aout1, aout2} = {16'h07d0, 16'h01f4, 16'hf830, 16'h0064};
    rd(ADDR_TERMINAL_STATUS, 16'h50a5);
    rd(ADDR_ANALOG_IN_FIRST, ANALOG_IN_FULL);
    rd(ADDR_ANALOG_IN_SECOND, 16'h01f4);
    rd(ADDR_ANALOG_OUT_FIRST, 16'hfc18);
    rd(ADDR_ANALOG_OUT_SECOND, 16'h0064);
  endtask
  // Bad function, unmapped address and reserved words.
  task automatic t_errors();
    acc(8'h10, ADDR_OPERATION_COMMAND, 16'h0, {8'h90, 16'h0, EXC_ILLEGAL_FUNC});
    acc(FUNC_READ, 16'h2404, 16'h0, {8'h83, 16'h0, EXC_ILLEGAL_ADDR});
    wr(ADDR_RESERVED_COMMAND, 16'hbeef);
    rd(ADDR_RESERVED_COMMAND, 16'h0000);
    rd(ADDR_RESERVED_MONITOR, 16'h0000);
    rd(ADDR_RESERVED_ANALOG, 16'h0000);
  endtask
  // Reset, scenarios and verdict.
  initial
  begin
    {fails, samples_checked} = '0;
    {sts, alm, rly, term, fcode, ofr, ocur, ovol, dcv} = '0;
    {ain1, ain2, aout1, aout2} = '0;
    reset_n = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    t_commands();
    t_status();
    t_alarm();
    t_monitor();
    t_io();
    t_errors();
    give_verdict();
  end
endmodule
